// ---- rtl/acs_cfg.svh ----
// Constants for the converter output stage and clock stabilizer.
// Assumes inclusion by bare name from the package and the modules.
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// Sample word and lane widths
`define ACS_SAMPLE_WIDTH 12
`define ACS_DDR_LANES 6
// Stabilizer counter width and limits
`define ACS_CNT_WIDTH 8
`define ACS_LOCK_CYCLES 8'h64
`define ACS_STOP_CYCLES 8'hFF
`define ACS_PERIOD_TOL 8'h01
`define ACS_CNT_ONE 8'h01
`define ACS_CNT_ZERO 8'h00
// Output mode register codes
`define ACS_OMR_CMOS 2'h0
`define ACS_OMR_DDR_CMOS 2'h1
`define ACS_OMR_DDR_LVDS 2'h2
// LVDS drive current code for the default current
`define ACS_LVDS_CUR_DEFAULT 3'h4

`endif

// ---- rtl/acs_pkg.sv ----
// Types shared by the output stage and the stabilizer.
// Assumes acs_cfg.svh is on the include path.
`include "acs_cfg.svh"

package acs_pkg;
	// Output mode in force
	typedef enum logic [1:0] {
		ACS_MODE_CMOS,
		ACS_MODE_DDR_CMOS,
		ACS_MODE_DDR_LVDS
	} acs_mode_e;

	// One sample word
	typedef logic [`ACS_SAMPLE_WIDTH-1:0] acs_word_t;
	// Stabilizer counter
	typedef logic [`ACS_CNT_WIDTH-1:0] acs_cnt_t;
endpackage

// ---- rtl/acs_dcs.sv ----
// Duty cycle stabilizer: samples the sample clock pin, finds its edges,
// regenerates a 50% internal clock and reports lock.
// Assumes sys_clk far faster than the sample clock.
`timescale 1ns/1ps
`include "acs_cfg.svh"

module acs_dcs
	import acs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic sample_clock_pos,
	input wire logic dcs_enable,
	output logic int_clk,
	output logic sample_rise,
	output logic dcs_locked
);
	// Pin synchroniser and edge history
	logic sync_a;
	logic sync_b;
	logic sync_c;
	// Cycles since last rising edge
	acs_cnt_t period_cnt;
	// Last measured period
	acs_cnt_t period_meas;
	// Sample clock edges counted since last disturbance
	acs_cnt_t lock_cnt;
	// Enable seen last cycle
	logic dcs_enable_d;
	logic freq_change;
	logic stopped;
	acs_cnt_t new_period;

	// Rising edge read from second and third stages only
	assign sample_rise = sync_b & ~sync_c;
	assign new_period = period_cnt + `ACS_CNT_ONE;
	assign stopped = (period_cnt == `ACS_STOP_CYCLES);
	// Period moved by more than sampling jitter
	assign freq_change = sample_rise &&
		((new_period > period_meas + `ACS_PERIOD_TOL) ||
		(new_period + `ACS_PERIOD_TOL < period_meas));

	// Two-stage synchroniser plus edge history
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			sync_c <= 1'b0;
		end else if (clk_en) begin
			sync_a <= sample_clock_pos;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	// Period measurement, saturating when the clock stops
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			period_cnt <= `ACS_CNT_ZERO;
			period_meas <= `ACS_CNT_ZERO;
		end else if (clk_en) begin
			if (sample_rise) begin
				period_cnt <= `ACS_CNT_ZERO;
				period_meas <= new_period;
			end else if (!stopped) begin
				period_cnt <= new_period;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			int_clk <= 1'b0;
		end else if (clk_en) begin
			if (!dcs_enable) begin
				// Bypass: follow the raw duty cycle
				int_clk <= sync_b;
			end else if (sample_rise) begin
				int_clk <= 1'b1;
			end else if (period_cnt + `ACS_CNT_ONE >= (period_meas >> 1) || stopped) begin
				int_clk <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			lock_cnt <= `ACS_CNT_ZERO;
			dcs_enable_d <= 1'b0;
		end else if (clk_en) begin
			dcs_enable_d <= dcs_enable;
			if (freq_change || stopped || (dcs_enable && !dcs_enable_d)) begin
				lock_cnt <= `ACS_CNT_ZERO;
			end else if (sample_rise && lock_cnt != `ACS_LOCK_CYCLES) begin
				lock_cnt <= lock_cnt + `ACS_CNT_ONE;
			end
		end
	end

	// Bypassed stabilizer never holds samples back
	// Stale count from before enable never reports lock
	assign dcs_locked = !dcs_enable || (dcs_enable_d && lock_cnt == `ACS_LOCK_CYCLES);
endmodule

// ---- rtl/acs_output_stage.sv ----
// Converter digital output stage: mode selection, sample capture and
// full-rate or double-data-rate output with forwarded output clock.
// Assumes conversion results arrive on sys_clk; pins are asynchronous.
`timescale 1ns/1ps
`include "acs_cfg.svh"

module acs_output_stage
	import acs_pkg::*;
(
	// System clock, 100 MHz
	input wire logic sys_clk,
	// Synchronous active-high reset
	input wire logic reset,
	// Freezes all state while low
	input wire logic clk_en,
	// Sample clock pin
	input wire logic sample_clock_pos,
	// Conversion result from the core
	input wire acs_word_t conv_word,
	// Over or underrange of that result
	input wire logic conv_overflow,
	// Programming mode pin, high for parallel
	input wire logic program_mode_select,
	// Chip select pin level
	input wire logic cs_pin_level,
	// Serial clock pin level
	input wire logic sck_pin_level,
	// Output mode register field
	input wire logic [1:0] output_mode_register,
	// LVDS current field of the output mode register
	input wire logic [2:0] lvds_current_register,
	// Stabilizer enable bit of the timing mode register
	input wire logic timing_mode_register,
	// Full-rate sample outputs
	output acs_word_t sample_bits,
	// Shared DDR lines, lowest lane first
	output logic [`ACS_DDR_LANES-1:0] ddr_shared_lines,
	// LVDS complement of the shared lines
	output logic [`ACS_DDR_LANES-1:0] ddr_shared_lines_comp,
	output logic overflow_flag,
	output logic overflow_flag_comp,
	output logic data_output_clock_true,
	output logic data_output_clock_comp,
	// Single-ended drivers active
	output logic cmos_drive_en,
	// Differential drivers active
	output logic lvds_drive_en,
	// LVDS drive current code
	output logic [2:0] lvds_current_code,
	// Samples are settled
	output logic samples_settled
);
	// Synchronised pin levels
	logic prog_a;
	logic prog_b;
	logic cs_a;
	logic cs_b;
	logic sck_a;
	logic sck_b;
	// Resolved selections
	acs_mode_e next_mode;
	acs_mode_e mode;
	logic next_dcs_en;
	logic dcs_en;
	logic [2:0] next_lvds_code;
	// Stabilizer outputs
	logic int_clk;
	logic sample_rise;
	logic dcs_locked;
	// Internal clock history for edge finding
	logic int_clk_d;
	logic clk_fall;
	logic clk_rise;
	// Word captured at the sample edge
	acs_word_t cap_word;
	logic cap_overflow;
	// Word being sent on the DDR lanes
	acs_word_t hold_word;

	// Pin synchronisers, two stages each
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prog_a <= 1'b0;
			prog_b <= 1'b0;
			cs_a <= 1'b0;
			cs_b <= 1'b0;
			sck_a <= 1'b0;
			sck_b <= 1'b0;
		end else if (clk_en) begin
			prog_a <= program_mode_select;
			prog_b <= prog_a;
			cs_a <= cs_pin_level;
			cs_b <= cs_a;
			sck_a <= sck_pin_level;
			sck_b <= sck_a;
		end
	end

	// Mode and stabilizer source selection
	always_comb begin
		next_mode = ACS_MODE_CMOS;
		next_dcs_en = 1'b0;
		next_lvds_code = `ACS_LVDS_CUR_DEFAULT;
		if (prog_b) begin
			next_mode = sck_b ? ACS_MODE_DDR_LVDS : ACS_MODE_CMOS;
			next_dcs_en = cs_b;
		end else begin
			next_dcs_en = timing_mode_register;
			next_lvds_code = lvds_current_register;
			case (output_mode_register)
				`ACS_OMR_CMOS: begin
					next_mode = ACS_MODE_CMOS;
				end
				`ACS_OMR_DDR_CMOS: begin
					next_mode = ACS_MODE_DDR_CMOS;
				end
				`ACS_OMR_DDR_LVDS: begin
					next_mode = ACS_MODE_DDR_LVDS;
				end
				default: begin
					// Unused code falls back to full rate
					next_mode = ACS_MODE_CMOS;
				end
			endcase
		end
	end

	// Registered selections and driver enables
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			mode <= ACS_MODE_CMOS;
			dcs_en <= 1'b0;
			lvds_current_code <= `ACS_LVDS_CUR_DEFAULT;
			cmos_drive_en <= 1'b1;
			lvds_drive_en <= 1'b0;
		end else if (clk_en) begin
			mode <= next_mode;
			dcs_en <= next_dcs_en;
			lvds_current_code <= next_lvds_code;
			cmos_drive_en <= (next_mode != ACS_MODE_DDR_LVDS);
			lvds_drive_en <= (next_mode == ACS_MODE_DDR_LVDS);
		end
	end

	// Stabilizer and sample clock edge finder
	acs_dcs u_dcs (
		.sys_clk(sys_clk),
		.reset(reset),
		.clk_en(clk_en),
		.sample_clock_pos(sample_clock_pos),
		.dcs_enable(dcs_en),
		.int_clk(int_clk),
		.sample_rise(sample_rise),
		.dcs_locked(dcs_locked)
	);

	// Edges of the internal clock
	assign clk_fall = int_clk_d & ~int_clk;
	assign clk_rise = ~int_clk_d & int_clk;

	// Internal clock history
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			int_clk_d <= 1'b0;
		end else if (clk_en) begin
			int_clk_d <= int_clk;
		end
	end

	// Capture one conversion at the sample edge
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cap_word <= '0;
			cap_overflow <= 1'b0;
		end else if (clk_en && sample_rise) begin
			cap_word <= conv_word;
			cap_overflow <= conv_overflow;
		end
	end

	// Forwarded output clock, true and complement
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			data_output_clock_true <= 1'b0;
			data_output_clock_comp <= 1'b1;
		end else if (clk_en) begin
			data_output_clock_true <= int_clk;
			data_output_clock_comp <= ~int_clk;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			samples_settled <= 1'b0;
		end else if (clk_en) begin
			samples_settled <= dcs_locked;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sample_bits <= '0;
			hold_word <= '0;
			overflow_flag <= 1'b0;
			overflow_flag_comp <= 1'b1;
		end else if (clk_en && clk_fall) begin
			hold_word <= cap_word;
			overflow_flag <= cap_overflow;
			overflow_flag_comp <= ~cap_overflow;
			sample_bits <= (mode == ACS_MODE_CMOS) ? cap_word : '0;
		end else if (clk_en && mode != ACS_MODE_CMOS) begin
			// Full-rate lines cleared at once in DDR modes
			sample_bits <= '0;
		end
	end

	// Per-lane DDR multiplexing
	genvar lane;
	generate
		for (lane = 0; lane < `ACS_DDR_LANES; lane = lane + 1) begin : g_lane
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					ddr_shared_lines[lane] <= 1'b0;
					ddr_shared_lines_comp[lane] <= 1'b1;
				end else if (clk_en) begin
					if (mode == ACS_MODE_CMOS) begin
						// Lanes idle in full-rate mode
						ddr_shared_lines[lane] <= 1'b0;
						ddr_shared_lines_comp[lane] <= 1'b1;
					end else if (clk_fall) begin
						// Even bit straight from the new word
						ddr_shared_lines[lane] <= cap_word[2*lane];
						ddr_shared_lines_comp[lane] <= ~cap_word[2*lane];
					end else if (clk_rise) begin
						// Odd bit of the same held word
						ddr_shared_lines[lane] <= hold_word[2*lane+1];
						ddr_shared_lines_comp[lane] <= ~hold_word[2*lane+1];
					end
				end
			end
		end
	endgenerate
endmodule

// ---- dv/acs_output_stage_props.sv ----
// Port checker for the converter output stage.
// Assumes it is bound onto acs_output_stage.
`timescale 1ns/1ps
`include "acs_cfg.svh"
module acs_output_stage_props
	import acs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic program_mode_select,
	input wire logic cs_pin_level,
	input wire logic sck_pin_level,
	input wire logic [1:0] output_mode_register,
	input wire logic timing_mode_register,
	input wire acs_word_t sample_bits,
	input wire logic [`ACS_DDR_LANES-1:0] ddr_shared_lines,
	input wire logic [`ACS_DDR_LANES-1:0] ddr_shared_lines_comp,
	input wire logic overflow_flag,
	input wire logic overflow_flag_comp,
	input wire logic data_output_clock_true,
	input wire logic data_output_clock_comp,
	input wire logic cmos_drive_en,
	input wire logic lvds_drive_en,
	input wire logic [2:0] lvds_current_code,
	input wire logic samples_settled
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Running in parallel or serial programming
	logic par;
	logic ser;
	assign par = clk_en && program_mode_select;
	assign ser = clk_en && !program_mode_select;
	property p_clk_pair;
		data_output_clock_comp == !data_output_clock_true && cmos_drive_en != lvds_drive_en;
	endproperty
	a_clk_pair: assert property (p_clk_pair) else $error("clock pair broken");
	property p_lane_pair;
		ddr_shared_lines_comp == ~ddr_shared_lines && overflow_flag_comp == !overflow_flag;
	endproperty
	a_lane_pair: assert property (p_lane_pair) else $error("lane pair broken");
	property p_par_cmos;
		(par && !sck_pin_level)[*5] |-> cmos_drive_en && ddr_shared_lines == 6'h00;
	endproperty
	a_par_cmos: assert property (p_par_cmos) else $error("parallel cmos wrong");
	property p_par_lvds;
		(par && sck_pin_level)[*4] |-> lvds_drive_en && lvds_current_code == 3'h4;
	endproperty
	a_par_lvds: assert property (p_par_lvds) else $error("parallel lvds wrong");
	property p_ser_ddr;
		(ser && output_mode_register == 2'h1)[*5] |-> cmos_drive_en && sample_bits == 12'h000;
	endproperty
	a_ser_ddr: assert property (p_ser_ddr) else $error("ddr cmos wrong");
	property p_fr_fall;
		(ser && output_mode_register == 2'h0)[*4] ##0
			($changed(sample_bits) || $changed(overflow_flag)) |-> $fell(data_output_clock_true);
	endproperty
	a_fr_fall: assert property (p_fr_fall) else $error("data moved off fall");
	property p_ddr_edge;
		(ser && output_mode_register == 2'h2)[*4] ##0 $changed(ddr_shared_lines)
			|-> $changed(data_output_clock_true);
	endproperty
	a_ddr_edge: assert property (p_ddr_edge) else $error("lane moved off edge");
	property p_par_dcs;
		(par && !cs_pin_level)[*5] |-> samples_settled;
	endproperty
	a_par_dcs: assert property (p_par_dcs) else $error("stabilizer not off");
	property p_dcs_on;
		(ser && $rose(timing_mode_register)) |-> ##5 !samples_settled[*8];
	endproperty
	a_dcs_on: assert property (p_dcs_on) else $error("settled too soon");
	c_lvds: cover property (lvds_drive_en && !program_mode_select);
	c_lock: cover property ($rose(samples_settled) && timing_mode_register);
	c_par: cover property (par && sck_pin_level && lvds_drive_en);
endmodule
bind acs_output_stage acs_output_stage_props i_props (.sys_clk, .reset, .clk_en,
	.program_mode_select, .cs_pin_level, .sck_pin_level, .output_mode_register,
	.timing_mode_register, .sample_bits, .ddr_shared_lines, .ddr_shared_lines_comp,
	.overflow_flag, .overflow_flag_comp, .data_output_clock_true, .data_output_clock_comp,
	.cmos_drive_en, .lvds_drive_en, .lvds_current_code, .samples_settled);

// ---- dv/acs_rx_model.sv ----
// Receiving capture logic: rebuilds words from the output pins.
// Assumes the bench tells it whether a DDR mode is in force.
`timescale 1ns/1ps
module acs_rx_model
	import acs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic ddr_mode,
	input wire logic data_output_clock_true,
	input wire acs_word_t sample_bits,
	input wire logic [5:0] ddr_shared_lines,
	input wire logic overflow_flag,
	output logic [12:0] rx_word,
	output logic rx_valid,
	output logic [7:0] hi_len,
	output logic [7:0] lo_len
);
	logic clk_q;
	logic of_q;
	logic [5:0] lines_q;
	logic [5:0] even;
	logic [7:0] run;
	acs_word_t w;
	always_comb begin
		for (int j = 0; j < 6; j++) begin
			w[2*j] = even[j];
			w[2*j+1] = lines_q[j];
		end
	end
	// capture on true clock rise (full rate) or fall (DDR, even bits at rise), phase lengths
	always_ff @(posedge sys_clk) begin
		clk_q <= data_output_clock_true;
		lines_q <= ddr_shared_lines;
		rx_valid <= 1'b0;
		run <= (data_output_clock_true != clk_q) ? 8'h01 : run + 8'h01;
		if (data_output_clock_true && !clk_q) begin
			lo_len <= run;
			of_q <= overflow_flag;
			even <= lines_q;
			if (!ddr_mode) begin
				rx_word <= {overflow_flag, sample_bits};
				rx_valid <= 1'b1;
			end
		end
		if (!data_output_clock_true && clk_q) begin
			hi_len <= run;
			if (ddr_mode) begin
				rx_word <= {of_q, w};
				rx_valid <= 1'b1;
			end
		end
	end
endmodule

// ---- dv/acs_output_stage_tb.sv ----
// Bench: reset, then mode table, stabilizer, parallel pins and clock-enable freeze.
// Assumes the receive model and the bound checker.
`timescale 1ns/1ps
module acs_output_stage_tb
	import acs_pkg::*;
;
	logic sys_clk = 0, reset = 1, clk_en = 1, sample_clock_pos = 0, pin_q = 0, run_clk = 1;
	logic program_mode_select = 0, cs_pin_level = 0, sck_pin_level = 0;
	logic timing_mode_register = 0, conv_overflow = 0, ddr_mode = 0;
	logic [1:0] output_mode_register = 2'h0;
	logic [2:0] lvds_current_register = 3'h2;
	acs_word_t conv_word = 12'h000;
	acs_word_t sample_bits;
	logic [5:0] ddr_shared_lines, ddr_shared_lines_comp;
	logic overflow_flag, overflow_flag_comp, data_output_clock_true, data_output_clock_comp;
	logic cmos_drive_en, lvds_drive_en, samples_settled, rx_valid;
	logic [2:0] lvds_current_code;
	logic [12:0] rx_word, tx_cur = 13'h0000, tx_prev = 13'h0000;
	logic [7:0] hi_len, lo_len;
	// Output snapshot for the clock-enable freeze test
	logic [12:0] snap;
	int fails = 0, cmp_count = 0, rises = 0;
	// Rows: parallel, sck, mode code, lvds, ddr
	logic [5:0] rows [6] = '{6'h00, 6'h05, 6'h0B, 6'h0C, 6'h24, 6'h33};
	acs_output_stage i_dut (.sys_clk, .reset, .clk_en, .sample_clock_pos, .conv_word,
		.conv_overflow, .program_mode_select, .cs_pin_level, .sck_pin_level,
		.output_mode_register, .lvds_current_register, .timing_mode_register, .sample_bits,
		.ddr_shared_lines, .ddr_shared_lines_comp, .overflow_flag, .overflow_flag_comp,
		.data_output_clock_true, .data_output_clock_comp, .cmos_drive_en, .lvds_drive_en,
		.lvds_current_code, .samples_settled);
	acs_rx_model i_rx (.sys_clk, .ddr_mode, .data_output_clock_true, .sample_bits,
		.ddr_shared_lines, .overflow_flag, .rx_word, .rx_valid, .hi_len, .lo_len);
	initial forever #5 sys_clk = ~sys_clk;
	// 12.5 Msps sample clock, 37.5% duty
	initial begin
		#3;
		forever if (run_clk) begin
			sample_clock_pos = 1;
			#30;
			sample_clock_pos = 0;
			#50;
		end else #10;
	end
	// New word at each sample clock rise
	always @(posedge sys_clk) begin
		pin_q <= sample_clock_pos;
		if (sample_clock_pos && !pin_q) begin
			rises <= rises + 1;
			tx_prev <= tx_cur;
			tx_cur <= tx_cur + 13'h0A5B;
			{conv_overflow, conv_word} <= tx_cur + 13'h0A5B;
		end
	end
	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic get_word;
		int i;
		i = 0;
		do begin
			@(negedge sys_clk);
			i++;
		end while (!rx_valid && i < 60);
		if (!rx_valid) begin
			fails++;
			close_out();
		end
	endtask
	task automatic wait_rises(input int n);
		int r, i;
		r = rises;
		for (i = 0; i < n * 12 && rises < r + n; i++) @(posedge sys_clk);
		if (rises < r + n) begin
			fails++;
			close_out();
		end
	endtask
	initial begin
		cyc(10);
		check("rst data", {data_output_clock_true, sample_bits}, 13'h0000);
		check("rst pins", {overflow_flag_comp, data_output_clock_comp, ddr_shared_lines_comp,
			cmos_drive_en, lvds_drive_en, lvds_current_code}, 13'h1FF4);
		check("rst settled", {12'h000, samples_settled}, 13'h0000);
		cyc(2);
		reset <= 0;
		for (int r = 0; r < 6; r++) begin
			@(posedge sys_clk);
			{program_mode_select, sck_pin_level, output_mode_register} <= rows[r][5:2];
			ddr_mode <= rows[r][0];
			cyc(8);
			check("drive", {8'h00, cmos_drive_en, lvds_drive_en, lvds_current_code},
				{8'h00, !rows[r][1], rows[r][1], rows[r][5] ? 3'h4 : 3'h2});
			get_word();
			get_word();
			repeat (3) begin
				get_word();
				check("word", rx_word, tx_prev);
			end
			$display("row %0d done", r);
		end
		@(posedge sys_clk);
		{program_mode_select, output_mode_register} <= 3'h0;
		ddr_mode <= 0;
		timing_mode_register <= 1;
		cyc(10);
		check("dcs on", {12'h000, samples_settled}, 13'h0000);
		wait_rises(90);
		check("lock early", {12'h000, samples_settled}, 13'h0000);
		wait_rises(20);
		check("lock", {12'h000, samples_settled}, 13'h0001);
		check("duty", {hi_len[5:0], 1'b0, lo_len[5:0]}, {6'h04, 1'b0, 6'h04});
		run_clk = 0;
		cyc(300);
		check("stop", {12'h000, samples_settled}, 13'h0000);
		run_clk = 1;
		$display("stabilizer done");
		@(posedge sys_clk);
		program_mode_select <= 1;
		cs_pin_level <= 1;
		cyc(8);
		check("cs high", {12'h000, samples_settled}, 13'h0000);
		cs_pin_level <= 0;
		cyc(6);
		check("cs low", {12'h000, samples_settled}, 13'h0001);
		$display("parallel pins done");
		clk_en <= 0;
		cyc(2);
		snap = {5'h00, data_output_clock_true, ddr_shared_lines, samples_settled};
		cyc(20);
		check("freeze", {5'h00, data_output_clock_true, ddr_shared_lines, samples_settled}, snap);
		clk_en <= 1;
		$display("freeze done");
		close_out();
	end
endmodule
